// ---- nvh_pkg.sv ----
package nvh_pkg;
  // Array geometry
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  // Unlock sequence addresses
  localparam logic [12:0] SEQ_A0 = 13'h0000;
  localparam logic [12:0] SEQ_A1 = 13'h1555;
  localparam logic [12:0] SEQ_A2 = 13'h0AAA;
  localparam logic [12:0] SEQ_A3 = 13'h1FFF;
  localparam logic [12:0] SEQ_A4 = 13'h10F0;
  localparam logic [12:0] SEQ_STORE = 13'h0F0F;
  localparam logic [12:0] SEQ_LOAD = 13'h0F0E;
  // Timing in the printed units and clock rate
  localparam int CLK_MHZ = 25;
  localparam int SAVE_TIME_MS = 10;
  localparam int POWERUP_LOAD_TIME_US = 550;
  localparam int SOFTWARE_LOAD_TIME_US = 20;
  localparam int GRACE_US = 1;
  localparam int STROBE_NS = 40;
  localparam int SAVE_CYC = SAVE_TIME_MS * 1000 * CLK_MHZ;
  localparam int POWERUP_LOAD_CYC = POWERUP_LOAD_TIME_US * CLK_MHZ;
  localparam int SOFTWARE_LOAD_CYC = SOFTWARE_LOAD_TIME_US * CLK_MHZ;
  localparam int GRACE_CYC = GRACE_US * CLK_MHZ;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  // Host commands
  typedef enum logic [2:0] {
    NVH_CMD_READ,
    NVH_CMD_WRITE,
    NVH_CMD_SW_STORE,
    NVH_CMD_SW_LOAD,
    NVH_CMD_HW_STORE
  } nvh_cmd_t;
  typedef struct packed {
    nvh_cmd_t cmd;
    logic [12:0] addr;
    logic [7:0] wdata;
  } nvh_req_t;
  // Pin bundle toward the memory
  typedef struct packed {
    logic sel_n;
    logic wr_n;
    logic oe_n;
    logic [12:0] byte_select_lines;
    logic [7:0] byte_lines_o;
    logic byte_lines_oe_n;
    logic busy_o;
    logic busy_oe_n;
  } nvh_pins_t;
endpackage : nvh_pkg

// ---- nvh_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for pin inputs
module nvh_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  // First stage read only by the second
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= '1;
      q_ff <= '1;
    end else begin
      meta_ff <= i_d;
      q_ff <= meta_ff;
    end
  end
  assign o_q = q_ff;
endmodule : nvh_sync
`default_nettype wire

// ---- nvh_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvh_ctrl #(
  parameter int SAVE_CYC = nvh_pkg::SAVE_CYC,
  parameter int POWERUP_LOAD_CYC = nvh_pkg::POWERUP_LOAD_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Request port
  input wire logic i_req_valid,
  input wire nvh_pkg::nvh_req_t i_req,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_rdata,
  // Memory pins
  input wire logic [7:0] i_byte_lines,
  input wire logic i_store_busy_line_n,
  output nvh_pkg::nvh_pins_t o_pins
);
  typedef enum logic [3:0] {
    NVH_ST_BOOT,
    NVH_ST_IDLE,
    NVH_ST_SETUP,
    NVH_ST_STROBE,
    NVH_ST_GAP,
    NVH_ST_HW_PULL,
    NVH_ST_WAIT_BUSY,
    NVH_ST_WAIT_NV,
    NVH_ST_DONE
  } nvh_state_t;

  // Sequence address for a given step
  function automatic logic [12:0] seq_addr(input logic [2:0] step, input logic load);
    case (step)
      3'h0: seq_addr = nvh_pkg::SEQ_A0;
      3'h1: seq_addr = nvh_pkg::SEQ_A1;
      3'h2: seq_addr = nvh_pkg::SEQ_A2;
      3'h3: seq_addr = nvh_pkg::SEQ_A3;
      3'h4: seq_addr = nvh_pkg::SEQ_A4;
      default: seq_addr = load ? nvh_pkg::SEQ_LOAD : nvh_pkg::SEQ_STORE;
    endcase
  endfunction : seq_addr

  localparam logic [2:0] LAST_STEP = 3'h5;
  localparam logic [23:0] STROBE_N = 24'(nvh_pkg::STROBE_CYC);
  localparam logic [23:0] GRACE_N = 24'(nvh_pkg::GRACE_CYC);

  nvh_state_t state_ff;
  nvh_pkg::nvh_req_t req_ff;
  logic [2:0] step_ff;
  logic [23:0] cnt_ff;
  logic [7:0] rdata_ff;
  logic rsp_ff;
  logic [12:0] addr_ff;
  logic [7:0] wdata_ff;
  logic sel_n_ff;
  logic wr_n_ff;
  logic oe_n_ff;
  logic dq_oe_n_ff;
  logic busy_pull_ff;
  logic busy_n_s;
  logic [7:0] dq_s;
  logic is_write;
  logic is_seq;
  logic nv_cmd;

  // Pin inputs come from the memory, outside our clock
  nvh_sync #(.W(1)) u_sync_busy (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_store_busy_line_n),
    .o_q(busy_n_s)
  );
  nvh_sync #(.W(8)) u_sync_dq (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_byte_lines),
    .o_q(dq_s)
  );

  assign is_write = (req_ff.cmd == nvh_pkg::NVH_CMD_WRITE);
  assign is_seq = (req_ff.cmd == nvh_pkg::NVH_CMD_SW_STORE) ||
                  (req_ff.cmd == nvh_pkg::NVH_CMD_SW_LOAD);
  assign nv_cmd = is_seq || (req_ff.cmd == nvh_pkg::NVH_CMD_HW_STORE);

  // Requests only taken when idle and busy line released
  // no access while busy
  assign o_req_ready = (state_ff == NVH_ST_IDLE) && busy_n_s;

  // Main sequencer
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= NVH_ST_BOOT;
      req_ff <= '0;
      step_ff <= 3'h0;
      cnt_ff <= 24'h00_0000;
    end else begin
      case (state_ff)
        NVH_ST_BOOT: begin
          if (cnt_ff >= 24'(POWERUP_LOAD_CYC - 1)) begin
            state_ff <= NVH_ST_IDLE;
            cnt_ff <= 24'h00_0000;
          end else begin
            cnt_ff <= cnt_ff + 24'h00_0001;
          end
        end
        NVH_ST_IDLE: begin
          step_ff <= 3'h0;
          cnt_ff <= 24'h00_0000;
          if (i_req_valid && o_req_ready) begin
            req_ff <= i_req;
            state_ff <= (i_req.cmd == nvh_pkg::NVH_CMD_HW_STORE) ? NVH_ST_HW_PULL
                                                                   : NVH_ST_SETUP;
          end
        end
        // Address settles one cycle before select falls
        NVH_ST_SETUP: begin
          state_ff <= NVH_ST_STROBE;
          cnt_ff <= 24'h00_0000;
        end
        NVH_ST_STROBE: begin
          if (cnt_ff >= STROBE_N) begin
            state_ff <= NVH_ST_GAP;
          end else begin
            cnt_ff <= cnt_ff + 24'h00_0001;
          end
        end
        NVH_ST_GAP: begin
          cnt_ff <= 24'h00_0000;
          if (is_seq && step_ff != LAST_STEP) begin
            step_ff <= step_ff + 3'h1;
            state_ff <= NVH_ST_SETUP;
          end else if (is_seq) begin
            state_ff <= NVH_ST_WAIT_BUSY;
          end else begin
            state_ff <= NVH_ST_DONE;
          end
        end
        // pulse one cycle longer than the grace window
        NVH_ST_HW_PULL: begin
          if (cnt_ff >= GRACE_N) begin
            state_ff <= NVH_ST_WAIT_BUSY;
            cnt_ff <= 24'h00_0000;
          end else begin
            cnt_ff <= cnt_ff + 24'h00_0001;
          end
        end
        // Give the memory the grace time to react
        NVH_ST_WAIT_BUSY: begin
          if (cnt_ff >= GRACE_N) begin
            state_ff <= NVH_ST_WAIT_NV;
            cnt_ff <= 24'h00_0000;
          end else begin
            cnt_ff <= cnt_ff + 24'h00_0001;
          end
        end
        // wait for save or load, bounded by save time
        NVH_ST_WAIT_NV: begin
          cnt_ff <= cnt_ff + 24'h00_0001;
          if (busy_n_s && (req_ff.cmd != nvh_pkg::NVH_CMD_SW_LOAD ||
              cnt_ff >= 24'(nvh_pkg::SOFTWARE_LOAD_CYC))) begin
            state_ff <= NVH_ST_DONE;
          end else if (cnt_ff >= 24'(SAVE_CYC) &&
                       cnt_ff >= 24'(nvh_pkg::SOFTWARE_LOAD_CYC)) begin
            // Cap never cuts a load short of its minimum time
            state_ff <= NVH_ST_DONE;
          end
        end
        NVH_ST_DONE: begin
          state_ff <= NVH_ST_IDLE;
        end
        default: begin
          state_ff <= NVH_ST_IDLE;
        end
      endcase
    end
  end

  // Pin drive, registered
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // idle with write strobe and select high
      sel_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      addr_ff <= 13'h0000;
      wdata_ff <= 8'h00;
      dq_oe_n_ff <= 1'b1;
      busy_pull_ff <= 1'b0;
    end else begin
      // Select low for STROBE_N+1 cycles, so synced read data settles
      sel_n_ff <= !(state_ff == NVH_ST_STROBE && cnt_ff <= STROBE_N);
      busy_pull_ff <= (state_ff == NVH_ST_HW_PULL);
      if (state_ff == NVH_ST_SETUP) begin
        addr_ff <= is_seq ? seq_addr(step_ff, req_ff.cmd == nvh_pkg::NVH_CMD_SW_LOAD)
                          : req_ff.addr;
        wdata_ff <= req_ff.wdata;
        // strobe low only for real writes
        wr_n_ff <= !is_write;
        // output enable only on plain reads
        oe_n_ff <= is_write || nv_cmd;
        dq_oe_n_ff <= !is_write;
      end else if (state_ff == NVH_ST_DONE || state_ff == NVH_ST_IDLE) begin
        // select ends write; strobe and data drop a cycle later
        wr_n_ff <= 1'b1;
        oe_n_ff <= 1'b1;
        dq_oe_n_ff <= 1'b1;
      end
    end
  end

  // sample a cycle after select rose; the sync adds two cycles
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= 8'h00;
      rsp_ff <= 1'b0;
    end else begin
      rsp_ff <= (state_ff == NVH_ST_DONE);
      if (state_ff == NVH_ST_DONE && req_ff.cmd == nvh_pkg::NVH_CMD_READ) begin
        rdata_ff <= dq_s;
      end
    end
  end

  assign o_rsp_valid = rsp_ff;
  assign o_rsp_rdata = rdata_ff;
  assign o_pins.sel_n = sel_n_ff;
  assign o_pins.wr_n = wr_n_ff;
  assign o_pins.oe_n = oe_n_ff;
  assign o_pins.byte_select_lines = addr_ff;
  assign o_pins.byte_lines_o = wdata_ff;
  assign o_pins.byte_lines_oe_n = dq_oe_n_ff;
  // Open drain: only ever pulls low
  assign o_pins.busy_o = 1'b0;
  assign o_pins.busy_oe_n = !busy_pull_ff;
endmodule : nvh_ctrl
`default_nettype wire

// ---- nvh_ctrl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvh_ctrl_chk #(
  parameter int SAVE_CYC = 1,
  parameter int POWERUP_LOAD_CYC = 1
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Watched ports
  input wire logic o_req_ready,
  input wire logic i_store_busy_line_n,
  input wire nvh_pkg::nvh_pins_t o_pins
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic [12:0] last_ff;
  // Address of the previous select pulse, for the unlock order
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      last_ff <= 13'h0000;
    else if ($fell(o_pins.sel_n))
      last_ff <= o_pins.byte_select_lines;
  end
  addr_hold_a: assert property (!o_pins.sel_n |-> $stable(o_pins.byte_select_lines))
    else $error("address moved while selected");
  oe_high_write_a: assert property (!o_pins.wr_n |-> o_pins.oe_n)
    else $error("output enable low during write");
  write_data_a: assert property (!o_pins.wr_n && !o_pins.sel_n |->
    !o_pins.byte_lines_oe_n && $stable(o_pins.byte_lines_o))
    else $error("write data not held");
  sel_ends_write_a: assert property ($rose(o_pins.sel_n) && !o_pins.wr_n |->
    !o_pins.byte_lines_oe_n ##1 o_pins.wr_n)
    else $error("write not ended by select");
  sel_pulse_a: assert property ($fell(o_pins.sel_n) |->
    ##1 !o_pins.sel_n ##[1:4] o_pins.sel_n)
    else $error("select pulse width wrong");
  seq_order_a: assert property ($fell(o_pins.sel_n) && o_pins.wr_n &&
    (o_pins.byte_select_lines == nvh_pkg::SEQ_STORE ||
     o_pins.byte_select_lines == nvh_pkg::SEQ_LOAD) |->
    last_ff == nvh_pkg::SEQ_A4)
    else $error("unlock step out of order");
  busy_gate_a: assert property (o_req_ready |-> $past(i_store_busy_line_n, 2))
    else $error("ready while busy line low");
  read_float_a: assert property (!o_pins.sel_n && o_pins.wr_n |->
    o_pins.byte_lines_oe_n)
    else $error("host drives data in a read");
endmodule : nvh_ctrl_chk
bind nvh_ctrl nvh_ctrl_chk #(
  .SAVE_CYC(SAVE_CYC),
  .POWERUP_LOAD_CYC(POWERUP_LOAD_CYC)
) u_nvh_ctrl_chk (
  .i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n),
  .o_req_ready(o_req_ready),
  .i_store_busy_line_n(i_store_busy_line_n),
  .o_pins(o_pins)
);
`default_nettype wire

// ---- nvh_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvh_mem_model #(
  parameter int STORE_NS = 2000,
  parameter int LOAD_NS = 10000
) (
  // Pins and resolved lines
  input wire nvh_pkg::nvh_pins_t i_pins,
  input wire logic [7:0] i_dq,
  input wire logic i_busy_n,
  // Drivers onto the lines
  output logic [7:0] o_dq,
  output logic o_dq_en,
  output logic o_busy_pull
);
  logic [7:0] ram [8192];
  logic [7:0] nv [8192];
  logic [12:0] seq [5] = '{nvh_pkg::SEQ_A0, nvh_pkg::SEQ_A1, nvh_pkg::SEQ_A2,
    nvh_pkg::SEQ_A3, nvh_pkg::SEQ_A4};
  logic written = 1'b0;
  logic off = 1'b0;
  int step = 0;
  initial begin
    o_busy_pull = 1'b0;
    foreach (nv[i]) nv[i] = 8'h00;
    ram = nv;
  end
  assign o_dq_en = !i_pins.sel_n && !i_pins.oe_n && i_pins.wr_n && i_busy_n && !off;
  assign o_dq = ram[i_pins.byte_select_lines];
  task automatic save();
    off = 1'b1;
    o_busy_pull = 1'b1;
    #(STORE_NS);
    nv = ram;
    written = 1'b0;
    o_busy_pull = 1'b0;
    off = 1'b0;
  endtask : save
  always @(posedge i_pins.sel_n or posedge i_pins.wr_n) begin
    if ((!i_pins.sel_n || !i_pins.wr_n) && i_busy_n && !off) begin
      ram[i_pins.byte_select_lines] = i_dq;
      written = 1'b1;
    end
  end
  always @(posedge i_pins.sel_n) begin
    if (!i_pins.wr_n || off)
      step = 0;
    else if (step < 5 && i_pins.byte_select_lines == seq[step])
      step++;
    else if (step == 5 && i_pins.byte_select_lines == nvh_pkg::SEQ_STORE) begin
      step = 0;
      save();
    end else if (step == 5 && i_pins.byte_select_lines == nvh_pkg::SEQ_LOAD) begin
      step = 0;
      off = 1'b1;
      #(LOAD_NS);
      ram = nv;
      written = 1'b0;
      off = 1'b0;
    end else
      step = int'(i_pins.byte_select_lines == nvh_pkg::SEQ_A0);
  end
  always @(negedge i_busy_n) begin
    if (!off) begin
      #(1000);
      if (written)
        save();
      off = 1'b1;
      wait (i_busy_n);
      off = 1'b0;
    end
  end
endmodule : nvh_mem_model
`default_nettype wire

// ---- nvh_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvh_ctrl_tb;
  logic clk = 1'b0;
  logic rst_n;
  logic req_valid;
  nvh_pkg::nvh_req_t req;
  logic o_req_ready, o_rsp_valid, pull, en, busy_w;
  logic [7:0] o_rsp_rdata, mdq, dq_w;
  logic [7:0] dq_last = 8'h00;
  nvh_pkg::nvh_pins_t pins;
  logic [7:0] mem [8192];
  logic [12:0] ad [8];
  logic [12:0] a;
  logic [31:0] r;
  logic [31:0] rs = 32'h5421_50b7;
  int bad_count = 0;
  int n_tests = 0;
  // Clock at 40 ns
  initial forever #20 clk = ~clk;
  // Pull-up on busy; released data lines keep changing
  assign busy_w = !(!pins.busy_oe_n || pull);
  assign dq_w = !pins.byte_lines_oe_n ? pins.byte_lines_o : en ? mdq : ~dq_last;
  always @(posedge clk) dq_last <= dq_w;
  nvh_ctrl #(.SAVE_CYC(400), .POWERUP_LOAD_CYC(10)) u_nvh_ctrl (.i_sys_clk(clk),
    .i_rst_n(rst_n), .i_req_valid(req_valid), .i_req(req), .o_req_ready(o_req_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata), .i_byte_lines(dq_w),
    .i_store_busy_line_n(busy_w), .o_pins(pins));
  nvh_mem_model u_nvh_mem_model (.i_pins(pins), .i_dq(dq_w), .i_busy_n(busy_w),
    .o_dq(mdq), .o_dq_en(en), .o_busy_pull(pull));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  // One request, held until taken, then wait for its answer
  task automatic do_req(input nvh_pkg::nvh_cmd_t c, input logic [12:0] aa,
      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{c, aa, d};
    do @(negedge clk); while (o_req_ready !== 1'b1 && ++n < 3000);
    @(posedge clk);
    req_valid <= 1'b0;
    do @(negedge clk); while (o_rsp_valid !== 1'b1 && ++n < 3000);
    if (n >= 3000) begin
      bad_count++;
      wrap_up();
    end
  endtask : do_req
  task automatic rd(input logic [12:0] aa, input logic [7:0] e);
    do_req(nvh_pkg::NVH_CMD_READ, aa, 8'h00);
    n_tests++;
    if (o_rsp_rdata !== e) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, o_rsp_rdata, e);
      bad_count++;
    end
  endtask : rd
  // Limit well above the expected run
  initial begin
    repeat (50000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Corner addresses first, then random ones clear of the unlock tail
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      ad[i] = i == 0 ? 13'h0000 : i == 1 ? 13'h1FFF : r[12:0] | 13'h1000;
      mem[ad[i]] = r[20:13];
      do_req(nvh_pkg::NVH_CMD_WRITE, ad[i], r[20:13]);
    end
    foreach (ad[i]) rd(ad[i], mem[ad[i]]);
    $display("read write test done");
    a = ad[2];
    do_req(nvh_pkg::NVH_CMD_SW_STORE, 13'h0000, 8'h00);
    do_req(nvh_pkg::NVH_CMD_WRITE, a, ~mem[a]);
    rd(a, ~mem[a]);
    do_req(nvh_pkg::NVH_CMD_SW_LOAD, 13'h0000, 8'h00);
    rd(a, mem[a]);
    $display("software save load test done");
    mem[a] = ~mem[a];
    do_req(nvh_pkg::NVH_CMD_WRITE, a, mem[a]);
    do_req(nvh_pkg::NVH_CMD_HW_STORE, 13'h0000, 8'h00);
    do_req(nvh_pkg::NVH_CMD_WRITE, a, 8'h5A);
    rd(a, 8'h5A);
    do_req(nvh_pkg::NVH_CMD_SW_LOAD, 13'h0000, 8'h00);
    rd(a, mem[a]);
    $display("busy line save test done");
    wrap_up();
  end
endmodule : nvh_ctrl_tb
`default_nettype wire
